// *** hdl/lbsr_params.svh ***
`ifndef LBSR_PARAMS_SVH
`define LBSR_PARAMS_SVH
// ==========================================
// Register byte offsets
`define LBSR_OFF_CTRL  8'h00
`define LBSR_OFF_DATA  8'h04
`define LBSR_OFF_STAT  8'h08
`define LBSR_OFF_CLR   8'h0C
`define LBSR_OFF_IEN   8'h10
// ==========================================
// Field positions and reset values
`define LBSR_CTRL_W    9
`define LBSR_CTRL_RST  9'h000
`define LBSR_DIV_LSB   9
`define LBSR_DIV_MSB   15
`define LBSR_DIV_RST   7'h40
`define LBSR_EVT_W     6
`define LBSR_EVT_RST   6'h00
`define LBSR_BRK_MIN   5'h0B
`endif

// *** hdl/lbsr_pkg.sv ***
package lbsr_pkg;
    typedef enum logic [1:0] {
        PAR_NONE, PAR_ZERO, PAR_EVEN, PAR_ODD
    } lbsr_par_e;

    typedef enum {
        ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP, ST_STOP2, ST_BRK
    } lbsr_state_e;

    // Control word, bit 0 first from the bottom
    typedef struct packed {
        logic      input_switch_sel1;
        logic      input_switch_sel0;
        logic      brk;
        logic      stop2;
        logic      msb;
        lbsr_par_e par;
        logic      inv;
        logic      en;
    } lbsr_cfg_s;

    // Status, clear and enable share this layout
    typedef struct packed {
        logic brk_err;
        logic brk_ok;
        logic ovr;
        logic perr;
        logic ferr;
        logic done;
    } lbsr_evt_s;
endpackage

// *** hdl/lbsr_rx.sv ***
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "lbsr_params.svh"
// How it works
// R1: One transfer-end interrupt per received frame
// R2: Framing, parity, overrun flags plus error interrupt
// R3: Shift bits at baud, byte to data
// R4: Software keeps divider field two or more
// R5: Line polarity selectable, idle high or low
// R6: Parity none, zero unchecked, even, odd
// R7: Stop bit detected raises receive-end interrupt
// R8: Break valid when low eleven bits or more
// R9: Short break is error, wait again
// R10: Software sets enable after wakeup edge
// R11: Software starts capture timer after break
// R12: Software derives bit period from sync field
// R13: Software stops channel before rebaud
// R14: Software handles checksum and reinitialises
// R15: Two switch bits route input to wakeup/capture
// R16: Bit time is two times divider plus two
// R17: Software never loads divider zero or one
// R18: Low count starts at start bit, high restarts
module lbsr_rx
    import lbsr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_serial_in,
    output logic             wake_edge_irq,
    output logic             capture_in,
    output logic             rx_end_irq,
    output logic             rx_error_irq,
    output logic             irq
);
    // ==========================================
    // Input synchroniser and routing
    logic        sync1_ff, sync2_ff;
    logic        wake_ff, cap_ff;
    lbsr_cfg_s   cfg;
    logic        lvl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            wake_ff  <= 1'b1;
            cap_ff   <= 1'b0;
        end else begin
            sync1_ff <= rx_serial_in;
            sync2_ff <= sync1_ff;
            wake_ff  <= cfg.input_switch_sel0 ? sync2_ff : 1'b1; // R15
            cap_ff   <= cfg.input_switch_sel1 ? sync2_ff : 1'b0; // R15
        end
    end
    assign wake_edge_irq = wake_ff;
    assign capture_in    = cap_ff;
    assign lvl           = sync2_ff ^ cfg.inv; // R5

    // ==========================================
    // Register file over APB
    logic [`LBSR_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [6:0]              div_ff, nxt_div;
    lbsr_evt_s               stat_ff, nxt_stat, ien_ff, nxt_ien, ev;
    logic [31:0]             rdata_ff, nxt_rdata;
    logic [7:0]              data_ff, nxt_data;
    logic                    full_ff, nxt_full;
    logic                    setup, wr, rd, hit;

    assign cfg     = lbsr_cfg_s'(ctrl_ff);
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign hit     = paddr == `LBSR_OFF_CTRL || paddr == `LBSR_OFF_DATA
                  || paddr == `LBSR_OFF_STAT || paddr == `LBSR_OFF_CLR
                  || paddr == `LBSR_OFF_IEN;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = rdata_ff;

    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_div   = div_ff;
        nxt_ien   = ien_ff;
        nxt_rdata = rdata_ff;
        nxt_stat  = stat_ff;
        if (wr && paddr == `LBSR_OFF_CTRL)
            nxt_ctrl = pwdata[`LBSR_CTRL_W-1:0];
        // Divider must stay at two or more; no guard here by design
        if (wr && paddr == `LBSR_OFF_DATA)
            nxt_div = pwdata[`LBSR_DIV_MSB:`LBSR_DIV_LSB]; // R4 R17 R13
        if (wr && paddr == `LBSR_OFF_IEN)
            nxt_ien = pwdata[`LBSR_EVT_W-1:0];
        if (wr && paddr == `LBSR_OFF_CLR)
            nxt_stat = stat_ff & ~lbsr_evt_s'(pwdata[`LBSR_EVT_W-1:0]);
        // Set after clear so a same-cycle event is never lost
        nxt_stat = nxt_stat | ev; // R2
        if (setup) begin
            unique case (paddr)
                `LBSR_OFF_CTRL: nxt_rdata = {23'h000000, ctrl_ff};
                `LBSR_OFF_DATA: nxt_rdata = {16'h0000, div_ff, 1'b0, data_ff}; // R3
                `LBSR_OFF_STAT: nxt_rdata = {26'h0000000, stat_ff};
                `LBSR_OFF_IEN:  nxt_rdata = {26'h0000000, ien_ff};
                default:        nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff  <= `LBSR_CTRL_RST;
            div_ff   <= `LBSR_DIV_RST;
            ien_ff   <= `LBSR_EVT_RST;
            stat_ff  <= `LBSR_EVT_RST;
            rdata_ff <= 32'h00000000;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            div_ff   <= nxt_div;
            ien_ff   <= nxt_ien;
            stat_ff  <= nxt_stat;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rx_end_irq   = stat_ff.done && ien_ff.done; // R1 R7
    assign rx_error_irq = |(stat_ff[5:1] & ien_ff[5:1]); // R2 R9
    assign irq          = rx_end_irq || rx_error_irq;

    // ==========================================
    // Receive state machine
    lbsr_state_e state_ff, nxt_state;
    logic [7:0]  tmr_ff, nxt_tmr, full_bit;
    logic [2:0]  bitn_ff, nxt_bitn;
    logic [7:0]  sh_ff, nxt_sh;
    logic        pbit_ff, nxt_pbit;
    logic [4:0]  low_ff, nxt_low;
    logic        tick, judge;

    assign tick     = tmr_ff == 8'h00;
    assign full_bit = {div_ff, 1'b1}; // R16
    assign judge    = tick && lvl && (state_ff == ST_BRK
                    || (state_ff == ST_STOP && cfg.brk));

    always_comb begin
        nxt_state = state_ff;
        nxt_tmr   = tick ? full_bit : tmr_ff - 8'h01;
        nxt_bitn  = bitn_ff;
        nxt_sh    = sh_ff;
        nxt_pbit  = pbit_ff;
        nxt_low   = low_ff;
        nxt_data  = data_ff;
        nxt_full  = full_ff;
        ev        = '0;
        if (rd && paddr == `LBSR_OFF_DATA)
            nxt_full = 1'b0;
        // Low-run counter covers every bit sample of a character
        if (tick && state_ff != ST_IDLE) begin
            if (lvl)
                nxt_low = 5'h00; // R18
            else if (low_ff != 5'h1F)
                nxt_low = low_ff + 5'h01; // R18
        end
        unique case (state_ff)
            ST_IDLE: begin
                nxt_low = 5'h00;
                if (!lvl) begin
                    nxt_state = ST_START;
                    nxt_tmr   = {1'b0, div_ff};
                end
            end
            ST_START: if (tick) begin
                // Glitch shorter than half a bit is dropped
                nxt_state = lvl ? ST_IDLE : ST_DATA;
                nxt_bitn  = 3'h0;
            end
            ST_DATA: if (tick) begin
                nxt_sh   = cfg.msb ? {sh_ff[6:0], lvl} : {lvl, sh_ff[7:1]}; // R3
                nxt_bitn = bitn_ff + 3'h1;
                if (bitn_ff == 3'h7)
                    nxt_state = cfg.par == PAR_NONE ? ST_STOP : ST_PAR; // R6
            end
            ST_PAR: if (tick) begin
                nxt_pbit  = lvl;
                nxt_state = ST_STOP;
            end
            ST_STOP: if (tick) begin
                ev.done = 1'b1; // R1 R7
                if (full_ff) begin
                    ev.ovr = 1'b1; // R2
                end else begin
                    nxt_data = sh_ff; // R3
                    nxt_full = 1'b1;
                end
                if (cfg.brk) begin
                    nxt_state = lvl ? ST_IDLE : ST_BRK;
                end else begin
                    ev.ferr   = !lvl; // R2
                    ev.perr   = (cfg.par == PAR_EVEN && (^{sh_ff, pbit_ff}))
                             || (cfg.par == PAR_ODD && !(^{sh_ff, pbit_ff})); // R6
                    nxt_state = cfg.stop2 ? ST_STOP2 : ST_IDLE;
                end
            end
            ST_STOP2: if (tick) begin
                ev.ferr   = !lvl; // R2
                nxt_state = ST_IDLE;
            end
            ST_BRK: if (tick && lvl)
                nxt_state = ST_IDLE;
        endcase
        if (judge) begin
            ev.brk_ok  = low_ff >= `LBSR_BRK_MIN; // R8
            ev.brk_err = low_ff < `LBSR_BRK_MIN; // R9
        end
        if (!cfg.en)
            nxt_state = ST_IDLE; // R10
        if (rd && paddr == `LBSR_OFF_DATA && ev.done && !full_ff)
            nxt_full = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            tmr_ff   <= 8'h00;
            bitn_ff  <= 3'h0;
            sh_ff    <= 8'h00;
            pbit_ff  <= 1'b0;
            low_ff   <= 5'h00;
            data_ff  <= 8'h00;
            full_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
            bitn_ff  <= nxt_bitn;
            sh_ff    <= nxt_sh;
            pbit_ff  <= nxt_pbit;
            low_ff   <= nxt_low;
            data_ff  <= nxt_data;
            full_ff  <= nxt_full;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_done_sets_end: assert property (ev.done |=> stat_ff.done) // R7
        else $error("frame end did not set status");
    a_ferr_sets: assert property (ev.ferr |=> stat_ff.ferr) // R2
        else $error("framing error not flagged");
    a_err_irq_out: assert property (stat_ff.ovr && ien_ff.ovr |-> rx_error_irq) // R2
        else $error("enabled overrun gave no error irq");
    a_break_ok: assert property (judge && low_ff >= 5'h0B |=> stat_ff.brk_ok) // R8
        else $error("long break not accepted");
    a_break_short: assert property (judge && low_ff < 5'h0B |=> stat_ff.brk_err) // R9
        else $error("short break not flagged");
    a_low_restart: assert property (tick && lvl && state_ff != ST_IDLE
        |=> low_ff == 5'h00) // R18
        else $error("low count not restarted");
    a_byte_stored: assert property (ev.done && !full_ff |=> data_ff == $past(sh_ff)) // R3
        else $error("received byte not stored");
    a_bit_period: assert property (tick && state_ff == ST_DATA
        |=> tmr_ff == {$past(div_ff), 1'b1}) // R16
        else $error("bit period reload wrong");
    a_capture_route: assert property (!cfg.input_switch_sel1 |=> !capture_in) // R15
        else $error("capture input not gated");

    c_frame_done: cover property (ev.done && !cfg.brk);
    c_break_ok: cover property (ev.brk_ok);
    c_overrun: cover property (ev.ovr);
endmodule

// *** sim/lbsr_lin_master.sv ***
`timescale 1ns/1ps
// ==========================================
// LIN master seen through its transceiver
module lbsr_lin_master (
    input  wire logic pclk,
    output logic      line
);
    int   bit_cycles = 6;
    logic inv        = 1'b0;
    // A released bus rests at the pull-up level, recessive after polarity
    initial line = 1'b1;
    // First wire bit is bits[0]; each bit lasts one full bit time
    task automatic put(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            line <= bits[i] ^ inv;
            repeat (bit_cycles - 1) @(posedge pclk);
        end
        @(posedge pclk);
        line <= ~inv;
    endtask
endmodule

// *** sim/lin_break_sync_receiver_tb.sv ***
`timescale 1ns/1ps
`include "lbsr_params.svh"
module lin_break_sync_receiver_tb;
    import lbsr_pkg::*;
    logic        pclk            = 1'b0;
    logic        presetn         = 1'b0;
    logic        psel            = 1'b0;
    logic        penable         = 1'b0;
    logic        pwrite          = 1'b0;
    logic [7:0]  paddr           = 8'h00;
    logic [31:0] pwdata          = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, line, wake, capt, rx_end, rx_err, irq;
    logic [32:0] exp_q[$];
    int          fail_count      = 0;
    int          samples_checked = 0;
    int          seed            = 61636;
    logic [6:0]  div             = 7'h02;
    logic [7:0]  b, b2;
    int          w;

    always #25 pclk = ~pclk;

    lbsr_lin_master m (.pclk(pclk), .line(line));
    lbsr_rx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_serial_in(line), .wake_edge_irq(wake), .capture_in(capt),
        .rx_end_irq(rx_end), .rx_error_irq(rx_err), .irq(irq));

    // ==========================================
    // Comparison and closing
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================
    // APB master; reads note {pslverr, prdata} for the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] want);
        int n;
        n = 0;
        @(posedge pclk);
        if (!wr) exp_q.push_back(want);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {1'b0, v});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v, 33'h0);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) check(33'h0, 33'h1);
            else check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // ==========================================
    // Frame builder: start, data, optional parity, stop
    task automatic frame(input logic [7:0] v, input logic [1:0] par, input logic msb,
                         input logic bad_par, input logic bad_stop);
        logic [7:0]  d;
        logic        p;
        if (msb) d = {<<{v}};
        else d = v;
        p = ((par == 2'h2) ? ^v : (par == 2'h3) ? ~^v : 1'b0) ^ bad_par;
        if (par == 2'h0) m.put({6'h00, ~bad_stop, d, 1'b0}, 10);
        else m.put({5'h00, ~bad_stop, p, d, 1'b0}, 11);
        repeat (10) @(posedge pclk);
    endtask

    task automatic got(input logic [7:0] v, input logic [31:0] st);
        rd(`LBSR_OFF_STAT, st);
        rd(`LBSR_OFF_DATA, {16'h0000, div, 1'h0, v});
        wr(`LBSR_OFF_CLR, 32'h3F);
    endtask

    // Width of the first low pulse on the capture route, in clock cycles
    task automatic low_width(output int wd);
        int n;
        n = 0;
        wd = 0;
        while (capt !== 1'b0 && n < 400) begin
            @(negedge pclk);
            n++;
        end
        while (capt === 1'b0 && wd < 400) begin
            @(negedge pclk);
            wd++;
        end
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        results();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`LBSR_OFF_CTRL, 32'h0);
        rd(`LBSR_OFF_DATA, 32'h0000_8000);
        rd(`LBSR_OFF_CLR, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 33'h1_0000_0000);
        $display("test reset done");
        wr(`LBSR_OFF_DATA, {16'h0000, div, 9'h000});
        wr(`LBSR_OFF_IEN, 32'h3F);
        for (int par = 0; par < 4; par++) begin
            b = $random(seed);
            wr(`LBSR_OFF_CTRL, {28'h0000000, par[1:0], 2'h1});
            frame(b, par[1:0], 1'b0, par == 1, 1'b0);
            @(negedge pclk);
            check({31'h0, rx_end, rx_err}, 33'h2);
            got(b, 32'h01);
        end
        $display("test parity modes done");
        wr(`LBSR_OFF_CTRL, 32'h9);
        frame(b, 2'h2, 1'b0, 1'b1, 1'b0);
        @(negedge pclk);
        check({32'h0, rx_err}, 33'h1);
        got(b, 32'h05);
        frame(b, 2'h2, 1'b0, 1'b0, 1'b1);
        got(b, 32'h03);
        b2 = $random(seed);
        frame(b, 2'h2, 1'b0, 1'b0, 1'b0);
        frame(b2, 2'h2, 1'b0, 1'b0, 1'b0);
        got(b, 32'h09);
        $display("test errors done");
        wr(`LBSR_OFF_CTRL, 32'h02);
        m.inv = 1'b1;
        m.put(16'h0000, 0);
        wr(`LBSR_OFF_CTRL, 32'h13);
        frame(b2, 2'h0, 1'b1, 1'b0, 1'b0);
        got(b2, 32'h01);
        wr(`LBSR_OFF_CTRL, 32'h00);
        m.inv = 1'b0;
        m.put(16'h0000, 0);
        $display("test polarity order done");
        wr(`LBSR_OFF_CTRL, 32'h41);
        m.put(16'h0000, 11);
        repeat (10) @(posedge pclk);
        got(8'h00, 32'h11);
        m.put(16'h0020, 16);
        repeat (10) @(posedge pclk);
        got(8'h10, 32'h21);
        $display("test break done");
        wr(`LBSR_OFF_CTRL, 32'h101);
        repeat (2) @(posedge pclk);
        fork
            frame(8'h55, 2'h0, 1'b0, 1'b0, 1'b0);
            low_width(w);
        join
        check(w, 2 * (div + 1));
        got(8'h55, 32'h01);
        wr(`LBSR_OFF_CTRL, 32'h000);
        div = 7'h03;
        m.bit_cycles = 2 * (div + 1);
        wr(`LBSR_OFF_DATA, {16'h0000, div, 9'h000});
        wr(`LBSR_OFF_CTRL, 32'h001);
        b = $random(seed);
        frame(b, 2'h0, 1'b0, 1'b0, 1'b0);
        got(b, 32'h01);
        wr(`LBSR_OFF_CTRL, 32'h041);
        m.put(16'h0000, 11);
        repeat (10) @(posedge pclk);
        got(8'h00, 32'h11);
        $display("test lin header done");
        wr(`LBSR_OFF_CTRL, 32'h01);
        wr(`LBSR_OFF_IEN, 32'h00);
        frame(b, 2'h0, 1'b0, 1'b0, 1'b0);
        @(negedge pclk);
        check({32'h0, irq}, 33'h0);
        wr(`LBSR_OFF_IEN, 32'h01);
        @(negedge pclk);
        check({32'h0, irq}, 33'h1);
        got(b, 32'h01);
        @(negedge pclk);
        check({32'h0, irq}, 33'h0);
        $display("test interrupt mask done");
        for (int i = 0; i < 2; i++) begin
            wr(`LBSR_OFF_CTRL, i ? 32'h180 : 32'h000);
            fork
                m.put(16'h0000, 1);
                begin
                    repeat (5) @(negedge pclk);
                    check({31'h0, wake, capt}, i ? 33'h0 : 33'h2);
                end
            join
            repeat (5) @(negedge pclk);
            check({31'h0, wake, capt}, i ? 33'h3 : 33'h2);
        end
        $display("test routing done");
        results();
    end
endmodule
